// ===== dcs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// host side: drives the conversion pins
// ****************************************
module dcs_host_model (
    // clock
    input wire logic mclk,
    // device pins
    output var logic convert_start_n,
    output var logic pair_select,
    output var logic power_down,
    output var logic reset_pin
);
    initial
    begin
        convert_start_n = 1'h1;
        pair_select = 1'h0;
        power_down = 1'h0;
        reset_pin = 1'h0;
    end

    // pair moves only while idle and settles before the next strobe
    task automatic set_pair(input logic p);
    begin
        @(posedge mclk);
        pair_select <= p;
        repeat (4) @(posedge mclk);
    end
    endtask

    task automatic drive_start(input logic lvl);
    begin
        @(posedge mclk);
        convert_start_n <= lvl;
    end
    endtask

    task automatic pulse_start(input int len);
    begin
        drive_start(1'h0);
        repeat (len) @(posedge mclk);
        convert_start_n <= 1'h1;
    end
    endtask

    task automatic set_ctl(input logic pd, input logic rst);
    begin
        @(posedge mclk);
        power_down <= pd;
        reset_pin <= rst;
    end
    endtask
endmodule
`default_nettype wire

// ===== dcs_pkg.sv
`default_nettype none
package dcs_pkg;
    // ****************************************
    // clock and timing
    // ****************************************
    localparam int CLK_MHZ = 200;
    localparam int APER_NS = 2;
    localparam int CONV_CH_NS = 450;
    localparam int ACQ_AUTO_NS = 250;
    localparam int APER_CYC_RAW = (APER_NS * CLK_MHZ + 999) / 1000;
    localparam int APER_CYC = (APER_CYC_RAW < 1) ? 1 : APER_CYC_RAW;
    localparam int CONV_CH_CYC_RAW = (CONV_CH_NS * CLK_MHZ + 999) / 1000;
    localparam int CONV_CH_CYC = (CONV_CH_CYC_RAW < 1) ? 1 : CONV_CH_CYC_RAW;
    localparam int ACQ_AUTO_CYC_RAW = (ACQ_AUTO_NS * CLK_MHZ + 999) / 1000;
    localparam int ACQ_AUTO_CYC = (ACQ_AUTO_CYC_RAW < 1) ? 1 : ACQ_AUTO_CYC_RAW;
    localparam int TMR_W = 16;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_ACQ = 4'h8;
    localparam logic [3:0] OFS_COUNT = 4'hC;
    localparam int CTRL_IMPULSE_BIT = 0;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_LOWPWR_BIT = 1;
    localparam int ST_PAIR_BIT = 2;
    localparam int ST_ARMED_BIT = 3;
    localparam int ST_PHASE_LSB = 4;
    localparam logic RST_IMPULSE = 1'b0;
    localparam logic [15:0] RST_ACQ = 16'(ACQ_AUTO_CYC);
    localparam logic [15:0] RST_COUNT = 16'h0000;

    // ****************************************
    // sequencer states
    // ****************************************
    typedef enum logic [2:0] {
        S_ACQ,
        S_AUTO,
        S_APER,
        S_CONVA,
        S_CONVB
    } dcs_state_t;
endpackage
`default_nettype wire

// ===== dcs_sequencer.sv
// The implementer's own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - pair_select low converts pair one, high converts pair two.
// - channel A always converts before channel B.
// - conversion runs to completion unless the reset input aborts it; no restart, power_down cannot abort.
// - convert start ignores chip select and read strobe.
// - impulse mode self-retriggers while convert_start_n stays low, power_down low and busy low.
// - fast mode needs one strobe per conversion.
// - impulse mode enters low power after each conversion, through acquisition.
// - read-out interface stays enabled during acquisition and low power.
// - fast mode up to 1 MSPS, impulse mode up to 888 kSPS.
// - inputs are held on convert_start_n falling edge after aperture delay.
// - reset input aborts conversion and floats data outputs.
module dcs_sequencer (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // device pins
    input wire logic convert_start_n,
    input wire logic pair_select,
    input wire logic power_down,
    input wire logic reset_pin,
    // converter control
    output logic busy_q,
    output logic hold_q,
    output logic mux_pair_q,
    output logic conv_a_q,
    output logic conv_b_q,
    output logic low_power_q,
    output logic data_oe_q,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [3:0] sync1_q, sync2_q;
    logic cnv_prev_q, cnv_s, pair_s, pd_s, reset_s, fall;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            sync1_q <= 4'h1;
            sync2_q <= 4'h1;
            cnv_prev_q <= 1'b1;
        end
        else
        begin
            sync1_q <= {reset_pin, power_down, pair_select, convert_start_n};
            sync2_q <= sync1_q;
            cnv_prev_q <= sync2_q[0];
        end
    end

    assign cnv_s = sync2_q[0];
    assign pair_s = sync2_q[1];
    assign pd_s = sync2_q[2];
    assign reset_s = sync2_q[3];
    assign fall = cnv_prev_q & ~cnv_s;

    // ****************************************
    // sequencer
    // ****************************************
    dcs_tmr_if #(.W(dcs_pkg::TMR_W)) tmr_if ();

    dcs_timer #(.W(dcs_pkg::TMR_W)) u_timer (
        .mclk(mclk),
        .rst_n(rst_n),
        .t(tmr_if.tmr)
    );

    dcs_pkg::dcs_state_t st_q, st_d;
    logic armed_q, armed_d, busy_d, hold_d, mux_pair_d, conv_a_d, conv_b_d;
    logic low_power_d, data_oe_d, conv_done, impulse_q;
    logic [15:0] acq_len_q, acq_len;

    // a zero auto-acquisition length would never expire
    assign acq_len = (acq_len_q == 16'h0000) ? 16'h0001 : acq_len_q;

    always_comb
    begin
        st_d = st_q;
        armed_d = armed_q | fall;
        hold_d = 1'b0;
        conv_done = 1'b0;
        tmr_if.load = 1'b0;
        tmr_if.len = '0;
        unique case (st_q)
            dcs_pkg::S_ACQ:
            begin
                // start decision looks at no read-out select at all
                if (!pd_s && fall)
                begin
                    st_d = dcs_pkg::S_APER;
                    tmr_if.load = 1'b1;
                    tmr_if.len = dcs_pkg::TMR_W'(dcs_pkg::APER_CYC);
                end
                else if (!pd_s && impulse_q && armed_q && !cnv_s)
                begin
                    // fast mode never reaches here, since this branch needs impulse_q and a new edge takes the first branch
                    st_d = dcs_pkg::S_AUTO;
                    tmr_if.load = 1'b1;
                    tmr_if.len = acq_len;
                end
            end
            dcs_pkg::S_AUTO:
            begin
                if (pd_s || cnv_s)
                    st_d = dcs_pkg::S_ACQ;
                else if (tmr_if.done)
                begin
                    st_d = dcs_pkg::S_APER;
                    tmr_if.load = 1'b1;
                    tmr_if.len = dcs_pkg::TMR_W'(dcs_pkg::APER_CYC);
                end
            end
            dcs_pkg::S_APER:
            begin
                if (tmr_if.done)
                begin
                    st_d = dcs_pkg::S_CONVA;
                    hold_d = 1'b1;
                    tmr_if.load = 1'b1;
                    tmr_if.len = dcs_pkg::TMR_W'(dcs_pkg::CONV_CH_CYC);
                end
            end
            dcs_pkg::S_CONVA:
            begin
                // strobes and power_down are not looked at here
                if (tmr_if.done)
                begin
                    st_d = dcs_pkg::S_CONVB;
                    tmr_if.load = 1'b1;
                    tmr_if.len = dcs_pkg::TMR_W'(dcs_pkg::CONV_CH_CYC);
                end
            end
            dcs_pkg::S_CONVB:
            begin
                if (tmr_if.done)
                begin
                    st_d = dcs_pkg::S_ACQ;
                    conv_done = 1'b1;
                end
            end
        endcase
        if (reset_s)
        begin
            st_d = dcs_pkg::S_ACQ;
            hold_d = 1'b0;
            conv_done = 1'b0;
        end
        busy_d = (st_d == dcs_pkg::S_APER) || (st_d == dcs_pkg::S_CONVA)
            || (st_d == dcs_pkg::S_CONVB);
        conv_a_d = (st_d == dcs_pkg::S_CONVA);
        conv_b_d = (st_d == dcs_pkg::S_CONVB);
        // mux follows the pin until hold and is frozen through conversion
        // a pin change during acquisition leaks into the sample
        mux_pair_d = (conv_a_d || conv_b_d) ? mux_pair_q : pair_s;
        low_power_d = low_power_q;
        if (!impulse_q || busy_d)
            low_power_d = 1'b0;
        else if (conv_done)
            low_power_d = 1'b1;
        // read-out stays usable in low power; only the reset pin floats it
        data_oe_d = !reset_s;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            st_q <= dcs_pkg::S_ACQ;
            armed_q <= 1'b0;
            busy_q <= 1'b0;
            hold_q <= 1'b0;
            mux_pair_q <= 1'b0;
            conv_a_q <= 1'b0;
            conv_b_q <= 1'b0;
            low_power_q <= 1'b0;
            data_oe_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            armed_q <= armed_d;
            busy_q <= busy_d;
            hold_q <= hold_d;
            mux_pair_q <= mux_pair_d;
            conv_a_q <= conv_a_d;
            conv_b_q <= conv_b_d;
            low_power_q <= low_power_d;
            data_oe_q <= data_oe_d;
        end
    end

    // ****************************************
    // register slave
    // ****************************************
    logic wait_d, impulse_d, commit;
    logic [31:0] rdata_d, rmux;
    logic [15:0] acq_len_d, count_q, count_d;
    logic [2:0] phase;
    // status phase codes rely on the state order: acq, auto, aperture, conv A, conv B
    assign phase = 3'(st_q);

    always_comb
    begin
        rmux = 32'h0000_0000;
        unique case (avs_address)
            dcs_pkg::OFS_CTRL: rmux[dcs_pkg::CTRL_IMPULSE_BIT] = impulse_q;
            dcs_pkg::OFS_STATUS:
            begin
                rmux[dcs_pkg::ST_BUSY_BIT] = busy_q;
                rmux[dcs_pkg::ST_LOWPWR_BIT] = low_power_q;
                rmux[dcs_pkg::ST_PAIR_BIT] = mux_pair_q;
                rmux[dcs_pkg::ST_ARMED_BIT] = armed_q;
                rmux[dcs_pkg::ST_PHASE_LSB +: 3] = phase;
            end
            dcs_pkg::OFS_ACQ: rmux[15:0] = acq_len_q;
            dcs_pkg::OFS_COUNT: rmux[15:0] = count_q;
            default: rmux = 32'h0000_0000;
        endcase
    end

    assign commit = avs_write && !avs_waitrequest;

    always_comb
    begin
        wait_d = 1'b1;
        rdata_d = avs_readdata;
        if ((avs_read || avs_write) && avs_waitrequest)
        begin
            wait_d = 1'b0;
            rdata_d = rmux;
        end
        // fast and impulse mode select
        impulse_d = impulse_q;
        acq_len_d = acq_len_q;
        count_d = count_q;
        if (commit && avs_address == dcs_pkg::OFS_CTRL && avs_byteenable[0])
            impulse_d = avs_writedata[dcs_pkg::CTRL_IMPULSE_BIT];
        if (commit && avs_address == dcs_pkg::OFS_ACQ)
        begin
            if (avs_byteenable[0])
                acq_len_d[7:0] = avs_writedata[7:0];
            if (avs_byteenable[1])
                acq_len_d[15:8] = avs_writedata[15:8];
        end
        if (commit && avs_address == dcs_pkg::OFS_COUNT)
            count_d = 16'h0000;
        // a finishing conversion wins over a clear in the same cycle
        if (conv_done)
            count_d = count_q + 16'h0001;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
            impulse_q <= dcs_pkg::RST_IMPULSE;
            acq_len_q <= dcs_pkg::RST_ACQ;
            count_q <= dcs_pkg::RST_COUNT;
        end
        else
        begin
            avs_waitrequest <= wait_d;
            avs_readdata <= rdata_d;
            impulse_q <= impulse_d;
            acq_len_q <= acq_len_d;
            count_q <= count_d;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    localparam int c_aper_max = dcs_pkg::APER_CYC + 2;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_no_restart;
        (st_q == dcs_pkg::S_CONVA) |=> (st_q == dcs_pkg::S_CONVA
            || st_q == dcs_pkg::S_CONVB || $past(reset_s));
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("conversion restarted");
    property p_a_before_b; $rose(conv_b_q) |-> $past(conv_a_q); endproperty
    a_a_before_b: assert property (p_a_before_b) else $error("b without a");
    property p_pair_follow;
        (st_q == dcs_pkg::S_ACQ) ##1 (st_q == dcs_pkg::S_ACQ) |-> mux_pair_q == $past(pair_s);
    endproperty
    a_pair_follow: assert property (p_pair_follow) else $error("mux not following pin");
    property p_busy_end;
        $fell(busy_q) |-> ($past(st_q) == dcs_pkg::S_CONVB || $past(reset_s));
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy fell early");
    property p_fast_no_auto;
        (!impulse_q && st_q == dcs_pkg::S_ACQ && !fall) |=> st_q != dcs_pkg::S_APER;
    endproperty
    a_fast_no_auto: assert property (p_fast_no_auto) else $error("fast mode self-start");
    property p_auto_start;
        (impulse_q && armed_q && st_q == dcs_pkg::S_ACQ && !cnv_s && !fall && !pd_s
            && !reset_s) |=> st_q == dcs_pkg::S_AUTO;
    endproperty
    a_auto_start: assert property (p_auto_start) else $error("no self-retrigger");
    property p_aperture;
        (st_q == dcs_pkg::S_ACQ && fall && !pd_s && !reset_s)
            |-> ##[1:c_aper_max] (hold_q || reset_s);
    endproperty
    a_aperture: assert property (p_aperture) else $error("hold late");
    property p_low_power; (impulse_q && conv_done) |=> low_power_q; endproperty
    a_low_power: assert property (p_low_power) else $error("no low power");
    property p_reset_abort;
        reset_s |=> (st_q == dcs_pkg::S_ACQ && !data_oe_q && !busy_q);
    endproperty
    a_reset_abort: assert property (p_reset_abort) else $error("reset did not abort");
    property p_shared_hold; hold_q |-> (conv_a_q && !conv_b_q) ##1 !hold_q; endproperty
    a_shared_hold: assert property (p_shared_hold) else $error("hold not single");
    property p_oe_lowpwr; (low_power_q && !reset_s) |=> data_oe_q; endproperty
    a_oe_lowpwr: assert property (p_oe_lowpwr) else $error("read-out off");

    c_conv: cover property (conv_done && !impulse_q);
    c_auto: cover property (st_q == dcs_pkg::S_AUTO ##1 st_q == dcs_pkg::S_AUTO);
    c_abort: cover property (conv_a_q && reset_s);
endmodule
`default_nettype wire

// ===== dcs_sequencer_notes_placeholder_removed.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== dcs_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dcs_sequencer_tb_top;
    logic mclk, rst_n;
    logic convert_start_n, pair_select, power_down, reset_pin;
    logic busy_q, hold_q, mux_pair_q, conv_a_q, conv_b_q, low_power_q, data_oe_q;
    logic [3:0] avs_address, avs_byteenable, be;
    logic avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata, rd, rnd_wd, exp_w;
    logic pair;
    int err_count, check_count, exp_count, i, n;

    dcs_host_model dcs_host_model_i (.mclk(mclk), .convert_start_n(convert_start_n),
        .pair_select(pair_select), .power_down(power_down), .reset_pin(reset_pin));

    dcs_sequencer dcs_sequencer_i (.mclk(mclk), .rst_n(rst_n),
        .convert_start_n(convert_start_n), .pair_select(pair_select),
        .power_down(power_down), .reset_pin(reset_pin), .busy_q(busy_q),
        .hold_q(hold_q), .mux_pair_q(mux_pair_q), .conv_a_q(conv_a_q),
        .conv_b_q(conv_b_q), .low_power_q(low_power_q), .data_oe_q(data_oe_q),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    initial
    begin
        mclk = 1'h0;
        forever #2.5 mclk = ~mclk;
    end

    // ****************************************
    // checking helpers
    // ****************************************
    task automatic tally_and_finish;
    begin
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    begin
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask

    function automatic logic [31:0] exp_busy_len();
        return 32'(dcs_pkg::APER_CYC + 2 * dcs_pkg::CONV_CH_CYC);
    endfunction

    // acquisition length after a write: only enabled low bytes move
    function automatic logic [31:0] exp_acq(input logic [15:0] old, input logic [31:0] wd,
        input logic [3:0] ben);
        logic [15:0] v;
    begin
        v = old;
        if (ben[0])
            v[7:0] = wd[7:0];
        if (ben[1])
            v[15:8] = wd[15:8];
        return {16'h0000, v};
    end
    endfunction

    // request held until waitrequest is seen low at an edge
    // only the watchdog ends a wait that never completes
    task automatic bus_xfer(input logic wr, input logic [3:0] a, input logic [31:0] wd,
        output logic [31:0] d);
    begin
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= wd;
        @(posedge mclk);
        while (avs_waitrequest !== 1'h0)
            @(posedge mclk);
        d = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        @(posedge mclk);
    end
    endtask

    task automatic wait_busy(input logic lvl, output int k);
    begin
        k = 0;
        while (busy_q !== lvl && k < 400)
        begin
            @(posedge mclk);
            k++;
        end
    end
    endtask

    // follows one conversion from busy rise to busy fall
    task automatic watch_conv(input logic p, input logic lp);
        int w, c, na, holds, hold_at;
        logic a_seen, bad;
    begin
        c = 0;
        na = 0;
        holds = 0;
        hold_at = 0;
        a_seen = 1'h0;
        bad = 1'h0;
        wait_busy(1'h1, w);
        cmp_word(32'(w < 400), 32'h1);
        while (busy_q === 1'h1 && c < 1000)
        begin
            c++;
            if (hold_q === 1'h1)
            begin
                holds++;
                hold_at = c;
            end
            if (conv_a_q === 1'h1)
            begin
                na++;
                a_seen = 1'h1;
            end
            if (conv_b_q === 1'h1 && (conv_a_q === 1'h1 || !a_seen))
                bad = 1'h1;
            if (a_seen && mux_pair_q !== p)
                bad = 1'h1;
            @(posedge mclk);
        end
        exp_count++;
        cmp_word(32'(c), exp_busy_len());
        cmp_word(32'(holds), 32'h1);
        cmp_word(32'(hold_at), 32'(dcs_pkg::APER_CYC + 1));
        cmp_word(32'(na), 32'(dcs_pkg::CONV_CH_CYC));
        cmp_word({31'h0, bad}, 32'h0);
        cmp_word({30'h0, low_power_q, data_oe_q}, {30'h0, lp, 1'h1});
    end
    endtask

    task automatic quiet(input int len);
        int hits;
    begin
        hits = 0;
        repeat (len)
        begin
            @(posedge mclk);
            if (busy_q !== 1'h0)
                hits++;
        end
        cmp_word(32'(hits), 32'h0);
    end
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        void'($urandom(32'h17FD));
        rst_n = 1'h0;
        avs_address = 4'h0;
        avs_read = 1'h0;
        avs_write = 1'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        repeat (4) @(posedge mclk);
        rst_n <= 1'h1;
        @(posedge mclk);
        bus_xfer(1'h0, dcs_pkg::OFS_CTRL, 32'h0, rd);
        cmp_word(rd, 32'(dcs_pkg::RST_IMPULSE));
        bus_xfer(1'h0, dcs_pkg::OFS_ACQ, 32'h0, rd);
        cmp_word(rd, 32'(dcs_pkg::RST_ACQ));
        bus_xfer(1'h0, dcs_pkg::OFS_COUNT, 32'h0, rd);
        cmp_word(rd, 32'(dcs_pkg::RST_COUNT));
        // fast mode; odd passes re-strobe with power_down high mid-conversion
        for (i = 0; i < 6; i++)
        begin
            pair = (i < 2) ? i[0] : 1'($urandom);
            dcs_host_model_i.set_pair(pair);
            fork
                watch_conv(pair, 1'h0);
                begin
                    dcs_host_model_i.pulse_start(1 + ($urandom % 4));
                    if (i[0])
                    begin
                        repeat (40) @(posedge mclk);
                        dcs_host_model_i.set_ctl(1'h1, 1'h0);
                        dcs_host_model_i.pulse_start(2);
                        dcs_host_model_i.set_ctl(1'h0, 1'h0);
                    end
                end
            join
        end
        // held low in fast mode gives exactly one conversion
        fork
            watch_conv(pair, 1'h0);
            dcs_host_model_i.drive_start(1'h0);
        join
        quiet(400);
        dcs_host_model_i.drive_start(1'h1);
        bus_xfer(1'h0, dcs_pkg::OFS_COUNT, 32'h0, rd);
        cmp_word(rd, 32'(exp_count));
        // self-repeating conversions in the reduced-power mode
        bus_xfer(1'h1, dcs_pkg::OFS_CTRL, 32'h1, rd);
        bus_xfer(1'h1, dcs_pkg::OFS_ACQ, 32'h14, rd);
        bus_xfer(1'h0, dcs_pkg::OFS_ACQ, 32'h0, rd);
        cmp_word(rd, 32'h14);
        dcs_host_model_i.drive_start(1'h0);
        watch_conv(pair, 1'h1);
        watch_conv(pair, 1'h1);
        fork
            watch_conv(pair, 1'h1);
            begin
                repeat (100) @(posedge mclk);
                dcs_host_model_i.drive_start(1'h1);
            end
        join
        quiet(300);
        bus_xfer(1'h0, dcs_pkg::OFS_COUNT, 32'h0, rd);
        cmp_word(rd, 32'(exp_count));
        bus_xfer(1'h1, dcs_pkg::OFS_COUNT, 32'h0, rd);
        bus_xfer(1'h0, dcs_pkg::OFS_COUNT, 32'h0, rd);
        cmp_word(rd, 32'h0);
        // byte lanes of the acquisition length, first pass upper byte only
        exp_w = 32'h14;
        for (i = 0; i < 4; i++)
        begin
            rnd_wd = $urandom;
            be = (i == 0) ? 4'h2 : 4'($urandom);
            avs_byteenable <= be;
            bus_xfer(1'h1, dcs_pkg::OFS_ACQ, rnd_wd, rd);
            avs_byteenable <= 4'hF;
            bus_xfer(1'h0, dcs_pkg::OFS_ACQ, 32'h0, rd);
            exp_w = exp_acq(exp_w[15:0], rnd_wd, be);
            cmp_word(rd, exp_w);
        end
        // reset pin aborts a running conversion and floats read-out
        bus_xfer(1'h1, dcs_pkg::OFS_CTRL, 32'h0, rd);
        dcs_host_model_i.pulse_start(2);
        wait_busy(1'h1, n);
        repeat (20) @(posedge mclk);
        dcs_host_model_i.set_ctl(1'h0, 1'h1);
        wait_busy(1'h0, n);
        cmp_word(32'(n < 10), 32'h1);
        repeat (4) @(posedge mclk);
        cmp_word({31'h0, data_oe_q}, 32'h0);
        dcs_host_model_i.set_ctl(1'h0, 1'h0);
        repeat (10) @(posedge mclk);
        bus_xfer(1'h0, dcs_pkg::OFS_COUNT, 32'h0, rd);
        cmp_word(rd, 32'h0);
        dcs_host_model_i.set_pair(~pair);
        fork
            watch_conv(~pair, 1'h0);
            dcs_host_model_i.pulse_start(3);
        join
        // status is read-only; idle fast mode shows armed and the new pair
        bus_xfer(1'h1, dcs_pkg::OFS_STATUS, 32'hFFFF_FFFF, rd);
        bus_xfer(1'h0, dcs_pkg::OFS_STATUS, 32'h0, rd);
        cmp_word(rd, {25'h0, 3'h0, 1'h1, ~pair, 2'h0});
        tally_and_finish();
    end

    // watchdog: the tests need well under 20000 cycles
    initial
    begin
        #300000;
        err_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ===== dcs_timer.sv
`timescale 1ns/1ps
`default_nettype none
module dcs_timer #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // control
    dcs_tmr_if.tmr t
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    // done marks the last cycle of a phase loaded with len cycles
    assign t.done = (cnt_q == W'(1));

    always_comb
    begin
        cnt_d = cnt_q;
        if (t.load)
            cnt_d = t.len;
        else if (cnt_q != '0)
            cnt_d = cnt_q - W'(1);
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end
endmodule
`default_nettype wire

// ===== dcs_tmr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dcs_tmr_if #(parameter int W = 16);
    logic load;
    logic [W-1:0] len;
    logic done;
    modport ctl (output load, output len, input done);
    modport tmr (input load, input len, output done);
endinterface
`default_nettype wire
